/* File: logic/config_loader.v */
// The strobed register port and the address map were left to the implementer.
`timescale 1ns/100ps
`include "config_load_defs.vh"

module config_loader
(
  input  wire        clock,
  input  wire        rst_n,
  input  wire        program_n,
  input  wire        init_status,
  input  wire        mode_select_2,
  input  wire        mode_select_1,
  input  wire        mode_select_0,
  input  wire        early_done_option,
  input  wire        serial_data_in,
  input  wire [7:0]  data_in,
  input  wire        chip_select_low_n,
  input  wire        chip_select_high,
  input  wire        write_strobe_n,
  input  wire        read_strobe_n,
  output reg         config_clock,
  output reg         serial_data_out,
  output reg         low_during_config,
  output reg         done,
  output reg         read_clock,
  output reg  [21:0] address,
  output reg         ready_busy
);

  // ----------------------------------------------------------------------
  // Constants and states
  // ----------------------------------------------------------------------
  localparam [4:0] SLOW_HALF_M1 = `CONFIG_CLOCK_SLOW_HALF_M1;
  localparam [4:0] FAST_HALF_M1 = `CONFIG_CLOCK_FAST_HALF_M1;
  localparam [5:0] RCLK_LOW_M1  = `READ_CLOCK_LOW_M1;
  localparam [1:0] ST_IDLE      = 2'h0;
  localparam [1:0] ST_LOAD      = 2'h1;
  localparam [1:0] ST_LATE      = 2'h2;
  localparam [1:0] ST_USER      = 2'h3;
  localparam       NSYNC        = 19;

  // ----------------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------------
  reg  [NSYNC-1:0] meta_ff;
  reg  [NSYNC-1:0] sync_ff;
  wire [NSYNC-1:0] pins_raw;

  assign pins_raw = {program_n, init_status, mode_select_2, mode_select_1,
                     mode_select_0, early_done_option, serial_data_in,
                     data_in, chip_select_low_n, chip_select_high,
                     write_strobe_n, read_strobe_n};

  // Every pin but clock and rst_n is asynchronous to clock, so each passes two flops first.
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      meta_ff <= {NSYNC{1'b0}};
      sync_ff <= {NSYNC{1'b0}};
    end
    else
    begin
      meta_ff <= pins_raw;
      sync_ff <= meta_ff;
    end
  end

  wire       s_prog_n  = sync_ff[18];
  wire       s_init    = sync_ff[17];
  wire [2:0] s_mode    = sync_ff[16:14];
  wire       s_early   = sync_ff[13];
  wire       s_din     = sync_ff[12];
  wire [7:0] s_data    = sync_ff[11:4];
  wire       s_write   = ~sync_ff[3] & sync_ff[2] & ~sync_ff[1] & sync_ff[0];

  // ----------------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------------
  reg  [1:0]  state_ff;
  reg  [2:0]  mode_ff;
  reg         run_ff;
  reg         fast_ff;
  reg  [4:0]  div_ff;
  reg  [15:0] bit_idx_ff;
  reg         hold_ff;
  reg         fwd_ff;
  reg         hold_en_ff;
  reg         fwd_en_ff;
  reg  [7:0]  in_byte_ff;
  reg         in_full_ff;
  reg  [7:0]  shift_ff;
  reg  [3:0]  shift_cnt_ff;
  reg         write_d_ff;
  reg  [3:0]  busy_cnt_ff;
  reg         rd_pend_ff;
  reg  [5:0]  rd_cnt_ff;
  reg  [3:0]  late_cnt_ff;

  wire is_serial  = (mode_ff == `MODE_MASTER_SERIAL);
  wire is_periph  = (mode_ff == `MODE_ASYNC_PERIPH);
  wire is_par     = (mode_ff == `MODE_PARALLEL_DOWN) |
                    (mode_ff == `MODE_PARALLEL_UP);
  wire mode_known = (s_mode == `MODE_MASTER_SERIAL) |
                    (s_mode == `MODE_ASYNC_PERIPH) |
                    (s_mode == `MODE_PARALLEL_DOWN) |
                    (s_mode == `MODE_PARALLEL_UP);

  // ----------------------------------------------------------------------
  // Config clock divider
  // ----------------------------------------------------------------------
  wire tick    = run_ff & (div_ff == (fast_ff ? FAST_HALF_M1 : SLOW_HALF_M1));
  wire rise    = tick & ~config_clock;
  wire fall    = tick & config_clock;
  wire write_e = write_d_ff & ~s_write;

  // The device owns the config clock; each rising edge steps the PROM.
  always @(posedge clock)
  begin
    if (!rst_n || !run_ff)
    begin
      div_ff       <= 5'h00;
      config_clock <= 1'b0;
    end
    else if (tick)
    begin
      div_ff       <= 5'h00;
      config_clock <= ~config_clock;
    end
    else
    begin
      div_ff <= div_ff + 5'h01;
    end
  end

  // ----------------------------------------------------------------------
  // Bit source: serial pin or byte converter
  // ----------------------------------------------------------------------
  wire       shifting = (shift_cnt_ff != 4'h0);
  wire       bit_ok   = rise & (is_serial | shifting | in_full_ff);
  wire       bit_val  = is_serial ? s_din :
                        (shifting ? shift_ff[7] : in_byte_ff[7]);
  wire       take     = rise & ~is_serial & ~shifting & in_full_ff;
  wire       last_bit = bit_ok & (bit_idx_ff == `CHAIN_END_BIT - 16'h0001);
  wire       forward  = (bit_idx_ff < `PREAMBLE_BITS) |
                        (bit_idx_ff >= `OWN_END_BIT);

  // Second stage of the converter; bytes leave most significant bit first.
  always @(posedge clock)
  begin
    if (!rst_n || state_ff == ST_IDLE)
    begin
      shift_ff     <= 8'h00;
      shift_cnt_ff <= 4'h0;
    end
    else if (take)
    begin
      shift_ff     <= {in_byte_ff[6:0], 1'b0};
      shift_cnt_ff <= 4'h7;
    end
    else if (rise && shifting)
    begin
      shift_ff     <= {shift_ff[6:0], 1'b0};
      shift_cnt_ff <= shift_cnt_ff - 4'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Bit counting, fast option and forwarding pipeline
  // ----------------------------------------------------------------------
  // The forwarded bit moves one stage per rise and leaves on a fall,
  // giving the one and a half period lag the next device expects.
  always @(posedge clock)
  begin
    if (!rst_n || state_ff == ST_IDLE)
    begin
      bit_idx_ff      <= 16'h0000;
      fast_ff         <= 1'b0;
      hold_ff         <= 1'b1;
      hold_en_ff      <= 1'b0;
      fwd_ff          <= 1'b1;
      fwd_en_ff       <= 1'b0;
      serial_data_out <= 1'b1;
    end
    else
    begin
      if (rise)
      begin
        hold_ff    <= bit_val;
        hold_en_ff <= bit_ok & forward;
        fwd_ff     <= hold_ff;
        fwd_en_ff  <= hold_en_ff;
      end
      if (bit_ok)
        bit_idx_ff <= bit_idx_ff + 16'h0001;
      if (bit_ok && bit_idx_ff == `FAST_FLAG_BIT && bit_val)
        fast_ff <= 1'b1;
      if (fall)
        serial_data_out <= fwd_en_ff ? fwd_ff : 1'b1;
    end
  end

  // ----------------------------------------------------------------------
  // Input register and busy handshake
  // ----------------------------------------------------------------------
  // Write data is caught while the write is active, so the host may drop
  // it as soon as the strobe rises. A write while full is ignored.
  always @(posedge clock)
  begin
    if (!rst_n || state_ff == ST_IDLE)
    begin
      write_d_ff  <= 1'b0;
      in_byte_ff  <= 8'h00;
      in_full_ff  <= 1'b0;
      busy_cnt_ff <= 4'h0;
      ready_busy  <= 1'b1;
      rd_pend_ff  <= 1'b0;
      rd_cnt_ff   <= 6'h00;
      read_clock  <= 1'b1;
    end
    else
    begin
      write_d_ff <= s_write & is_periph;
      if (s_write && is_periph && !in_full_ff)
        in_byte_ff <= s_data;
      if (write_e && !in_full_ff)
      begin
        in_full_ff  <= 1'b1;
        ready_busy  <= 1'b0;
        busy_cnt_ff <= 4'h0;
      end
      else if (!ready_busy)
      begin
        if (rise && busy_cnt_ff != 4'hF)
          busy_cnt_ff <= busy_cnt_ff + 4'h1;
        if (!in_full_ff && busy_cnt_ff > `BUSY_MIN_PERIODS)
          ready_busy <= 1'b1;
      end
      if (take)
        in_full_ff <= 1'b0;
      // Parallel fetch runs on its own timer so the first byte needs no
      // config clock; later fetches overlap the shifting byte.
      if (is_par && state_ff == ST_LOAD && !in_full_ff && !rd_pend_ff &&
          bit_idx_ff < `CHAIN_END_BIT)
      begin
        rd_pend_ff <= 1'b1;
        rd_cnt_ff  <= 6'h00;
        read_clock <= 1'b0;
      end
      else if (rd_pend_ff)
      begin
        if (rd_cnt_ff == RCLK_LOW_M1)
        begin
          rd_pend_ff <= 1'b0;
          read_clock <= 1'b1;
          in_byte_ff <= s_data;
          in_full_ff <= 1'b1;
        end
        else
          rd_cnt_ff <= rd_cnt_ff + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Address counter for the parallel memory
  // ----------------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n || state_ff == ST_IDLE)
      address <= (s_mode == `MODE_PARALLEL_DOWN) ? `ADDR_DOWN_START
                                                 : `ADDR_UP_START;
    else if (rd_pend_ff && rd_cnt_ff == RCLK_LOW_M1)
      address <= (mode_ff == `MODE_PARALLEL_DOWN) ? address - 22'h000001
                                                  : address + 22'h000001;
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  // Loading waits for program release and every chained init pin High.
  // Without early done, done rises a few periods after the last bit, so
  // a PROM enabled by done may still be driving the serial input then.
  always @(posedge clock)
  begin
    if (!rst_n || !s_prog_n)
    begin
      state_ff          <= ST_IDLE;
      mode_ff           <= `MODE_MASTER_SERIAL;
      run_ff            <= 1'b0;
      late_cnt_ff       <= 4'h0;
      done              <= 1'b0;
      low_during_config <= 1'b1;
    end
    else
    begin
      case (state_ff)
        ST_IDLE:
        begin
          if (s_init && mode_known)
          begin
            mode_ff           <= s_mode;
            state_ff          <= ST_LOAD;
            run_ff            <= (s_mode == `MODE_MASTER_SERIAL) |
                                 (s_mode == `MODE_ASYNC_PERIPH);
            low_during_config <= 1'b0;
          end
        end
        ST_LOAD:
        begin
          if (rd_pend_ff && rd_cnt_ff == RCLK_LOW_M1)
            run_ff <= 1'b1;
          if (last_bit)
          begin
            late_cnt_ff <= 4'h0;
            state_ff    <= ST_LATE;
            if (s_early)
            begin
              done              <= 1'b1;
              low_during_config <= 1'b1;
            end
          end
        end
        ST_LATE:
        begin
          if (rise)
          begin
            late_cnt_ff <= late_cnt_ff + 4'h1;
            if (late_cnt_ff == `LATE_DONE_PERIODS - 4'h1)
            begin
              done              <= 1'b1;
              low_during_config <= 1'b1;
              state_ff          <= ST_USER;
            end
          end
        end
        ST_USER:
        begin
          low_during_config <= 1'b1;
          done              <= 1'b1;
          if (fall) // Stopping on a fall never cuts a high phase short.
            run_ff <= 1'b0;
        end
        default:
          state_ff <= ST_IDLE;
      endcase
    end
  end

endmodule

/* File: logic/config_load_defs.vh */
`ifndef CONFIG_LOAD_DEFS_VH
`define CONFIG_LOAD_DEFS_VH

// ----------------------------------------------------------------------
// Mode select codes, mode_select_2 down to mode_select_0
// ----------------------------------------------------------------------
`define MODE_MASTER_SERIAL   3'h0
`define MODE_ASYNC_PERIPH    3'h5
`define MODE_PARALLEL_DOWN   3'h6
`define MODE_PARALLEL_UP     3'h4

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS        40
`define CONFIG_CLOCK_SLOW_PERIOD_NS  1280
`define CONFIG_CLOCK_FAST_FACTOR     8
// Last count of each half period and of the fetch low phase, sized for
// the counters; they follow from the periods above at a 40 ns clock.
`define CONFIG_CLOCK_SLOW_HALF_M1    5'h0F
`define CONFIG_CLOCK_FAST_HALF_M1    5'h01
`define READ_CLOCK_LOW_NS    1280
`define READ_CLOCK_LOW_M1    6'h1F
`define BUSY_MIN_PERIODS     4'h2
`define LATE_DONE_PERIODS    4'h4

// ----------------------------------------------------------------------
// Bitstream layout, counted in bits from the first bit loaded
// ----------------------------------------------------------------------
`define PREAMBLE_BITS        16'h0008
`define OWN_END_BIT          16'h0048
`define CHAIN_END_BIT        16'h0080
`define FAST_FLAG_BIT        16'h000C

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define ADDR_UP_START        22'h000000
`define ADDR_DOWN_START      22'h3FFFFF

`endif

/* File: dv/config_loader_checker.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Port checker
// ----------------------------------------------------------------------
module config_loader_checker
(
  input wire        clock,
  input wire        rst_n,
  input wire        program_n,
  input wire        init_status,
  input wire        mode_select_2,
  input wire        mode_select_1,
  input wire        mode_select_0,
  input wire        early_done_option,
  input wire        serial_data_in,
  input wire [7:0]  data_in,
  input wire        chip_select_low_n,
  input wire        chip_select_high,
  input wire        write_strobe_n,
  input wire        read_strobe_n,
  input wire        config_clock,
  input wire        serial_data_out,
  input wire        low_during_config,
  input wire        done,
  input wire        read_clock,
  input wire [21:0] address,
  input wire        ready_busy
);
  reg [9:0] busy_ff;

  // Cycles spent busy; saturates so a stuck output cannot wrap to zero.
  always @(posedge clock)
    if (!rst_n || ready_busy)
      busy_ff <= 10'h000;
    else if (busy_ff != 10'h3FF)
      busy_ff <= busy_ff + 10'h001;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_busy_min: assert property ($rose(ready_busy) |-> busy_ff >= 10'h040)
    else $error("busy interval too short");
  a_busy_max: assert property (!ready_busy |-> busy_ff < 10'h130)
    else $error("busy interval too long");
  a_busy_after_write: assert property ($rose(write_strobe_n) &&
    !chip_select_low_n && chip_select_high && read_strobe_n && ready_busy
    && !low_during_config |-> ##[2:6] !ready_busy)
    else $error("no busy after a byte write");
  a_ldc_user_high: assert property (done |-> low_during_config)
    else $error("low_during_config low after done");
  a_dout_on_fall: assert property ($changed(serial_data_out) |->
    !config_clock)
    else $error("serial output changed with config clock high");
  a_config_clock_high: assert property ($rose(config_clock) |=> config_clock)
    else $error("config clock high phase too short");
  a_config_clock_low: assert property ($fell(config_clock) |=> !config_clock)
    else $error("config clock low phase too short");
  a_fetch_steps: assert property ($rose(read_clock) |->
    $changed(address))
    else $error("address did not step after a fetch");
  a_fetch_low: assert property ($fell(read_clock) |->
    !read_clock[*8] ##[22:26] read_clock)
    else $error("read clock low phase wrong");
endmodule

bind config_loader config_loader_checker config_loader_checker_i
(
  .clock(clock), .rst_n(rst_n), .program_n(program_n),
  .init_status(init_status), .mode_select_2(mode_select_2),
  .mode_select_1(mode_select_1), .mode_select_0(mode_select_0),
  .early_done_option(early_done_option), .serial_data_in(serial_data_in),
  .data_in(data_in), .chip_select_low_n(chip_select_low_n),
  .chip_select_high(chip_select_high), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .config_clock(config_clock),
  .serial_data_out(serial_data_out), .low_during_config(low_during_config),
  .done(done), .read_clock(read_clock), .address(address),
  .ready_busy(ready_busy)
);

/* File: dv/config_memory_model.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Serial PROM and byte-wide memory on the far side
// ----------------------------------------------------------------------
module config_memory_model
(
  input  wire         clear_n,
  input  wire         config_clock,
  input  wire         done,
  input  wire [21:0]  address,
  input  wire         count_down,
  input  wire [0:127] image,
  output wire         serial_data_in,
  output wire [7:0]   mem_data
);
  reg  [6:0] bit_ff;
  wire [3:0] byte_idx;

  // Each rise advances the bit counter; no minimum period is modelled, so
  // the fast rate is always followed.
  always @(posedge config_clock or negedge clear_n)
    if (!clear_n)
      bit_ff <= 7'h00;
    else
      bit_ff <= bit_ff + 7'h01;

  // Enable comes from done; a disabled PROM shows the inverse of its last
  // bit so a stale value cannot pass for data.
  assign serial_data_in = done ? ~image[bit_ff] : image[bit_ff];

  // The memory holds the image from its lowest or its highest address.
  assign byte_idx = count_down ? ~address[3:0] : address[3:0];
  assign mem_data = image[{byte_idx, 3'h0} +: 8];
endmodule

/* File: dv/tb_top.sv */
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------------
module tb_top;
  typedef struct packed {logic [2:0] md; logic fast; logic early;
    logic [21:0] addr1;} row_t;
  reg          clock, rst_n, program_n, init_status, early_done_option;
  reg          cs_low_n, ws_n, cc_prev;
  reg  [2:0]   mode;
  reg  [7:0]   host_data;
  reg  [0:127] image;
  row_t        rows [5];
  wire         config_clock, serial_data_out, low_during_config, done;
  wire         read_clock, ready_busy, serial_data_in;
  wire [21:0]  address;
  wire [7:0]   mem_data;
  integer      err_count, comparisons, rise_cnt, gap, gap_late, i, j, k;

  config_loader config_loader_i (.clock(clock), .rst_n(rst_n),
    .program_n(program_n), .init_status(init_status),
    .mode_select_2(mode[2]), .mode_select_1(mode[1]),
    .mode_select_0(mode[0]), .early_done_option(early_done_option),
    .serial_data_in(serial_data_in),
    .data_in(mode == 3'h5 ? host_data : mem_data),
    .chip_select_low_n(cs_low_n), .chip_select_high(1'b1),
    .write_strobe_n(ws_n), .read_strobe_n(1'b1),
    .config_clock(config_clock), .serial_data_out(serial_data_out),
    .low_during_config(low_during_config), .done(done),
    .read_clock(read_clock), .address(address), .ready_busy(ready_busy));

  config_memory_model config_memory_model_i (.clear_n(rst_n & program_n),
    .config_clock(config_clock), .done(done), .address(address),
    .count_down(mode[1]), .image(image), .serial_data_in(serial_data_in),
    .mem_data(mem_data));

  task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task close_out;
    $display("comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Called once per waited cycle; a spent bound ends the run.
  task guard(input integer lim);
    k = k + 1;
    if (k > lim)
    begin
      err_count = err_count + 1;
      $display("MISMATCH at %0t: wait ran out", $time);
      close_out;
    end
  endtask

  task restart;
    @(posedge clock);
    program_n <= 1'b0;
    repeat (4) @(posedge clock);
    rise_cnt = 0;
    program_n <= 1'b1;
  endtask

  // Host byte write; the bus is inverted once the strobe ends because
  // data need not stand past that edge.
  task host_write(input logic [7:0] b);
    k = 0;
    while (ready_busy !== 1'b1)
    begin
      @(negedge clock);
      guard(400);
    end
    @(posedge clock);
    host_data <= b;
    cs_low_n <= 1'b0;
    ws_n <= 1'b0;
    repeat (4) @(posedge clock);
    ws_n <= 1'b1;
    host_data <= ~b;
    @(posedge clock);
    cs_low_n <= 1'b1;
    k = 0;
    while (ready_busy !== 1'b0)
    begin
      @(negedge clock);
      guard(10);
    end
  endtask

  initial
  begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  // Count config clock rises and sample forwarded bits the way the next
  // device in the chain would, on the rise after each fall.
  always @(posedge clock)
  begin
    cc_prev <= config_clock;
    gap = gap + 1;
    if (config_clock === 1'b1 && cc_prev === 1'b0)
    begin
      if (rise_cnt == 30)
        gap_late = gap;
      if (mode == 3'h0 && rise_cnt >= 2 && rise_cnt < 130 &&
          (rise_cnt < 10 || rise_cnt >= 74))
        check(serial_data_out, image[rise_cnt - 2]);
      rise_cnt = rise_cnt + 1;
      gap = 0;
    end
  end

  initial
  begin
    rst_n = 1'b0;
    program_n = 1'b1;
    init_status = 1'b1;
    early_done_option = 1'b0;
    cs_low_n = 1'b1;
    ws_n = 1'b1;
    mode = 3'h0;
    host_data = 8'h00;
    image = 128'hFFA55A3C0F1E2D4B96870F1E2D3C4B5A;
    err_count = 0;
    comparisons = 0;
    rise_cnt = 0;
    gap = 0;
    gap_late = 0;
    cc_prev = 1'b0;
    rows[0] = {3'h0, 1'h0, 1'h0, 22'h000000};
    rows[1] = {3'h0, 1'h1, 1'h1, 22'h000000};
    rows[2] = {3'h5, 1'h0, 1'h0, 22'h000000};
    rows[3] = {3'h4, 1'h0, 1'h0, 22'h000001};
    rows[4] = {3'h6, 1'h0, 1'h0, 22'h3FFFFE};
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    for (i = 0; i < 5; i = i + 1)
    begin
      mode <= rows[i].md;
      early_done_option <= rows[i].early;
      image[12] <= rows[i].fast;
      restart;
      k = 0;
      if (rows[i].md == 3'h5)
        for (j = 0; j < 16; j = j + 1)
          host_write(image[8 * j +: 8]);
      else if (rows[i].md != 3'h0)
      begin
        while (read_clock !== 1'b0)
        begin
          @(negedge clock);
          guard(200);
        end
        while (read_clock !== 1'b1)
        begin
          @(negedge clock);
          guard(200);
        end
        check(rise_cnt, 0);
        check(address, rows[i].addr1);
      end
      k = 0;
      while (done !== 1'b1)
      begin
        @(negedge clock);
        guard(9000);
      end
      if (rows[i].md == 3'h0)
      begin
        check(gap_late, rows[i].fast ? 4 : 32);
        check(rows[i].early ? rise_cnt <= 129 : rise_cnt >= 131, 1);
      end
      repeat (3) @(negedge clock);
      check(low_during_config, 1'b1);
    end

    // A reset in mid-load must bring every output back to idle.
    mode <= 3'h0;
    restart;
    repeat (100) @(posedge clock);
    rst_n <= 1'b0;
    init_status <= 1'b0;
    repeat (5) @(posedge clock);
    @(negedge clock);
    check({config_clock, serial_data_out, low_during_config, done,
           read_clock, ready_busy}, 6'h1B);
    check(address, 22'h000000);
    @(posedge clock);
    rst_n <= 1'b1;
    rise_cnt = 0;
    repeat (200) @(posedge clock);
    check(rise_cnt, 0);
    init_status <= 1'b1;
    k = 0;
    while (rise_cnt == 0)
    begin
      @(negedge clock);
      guard(200);
    end
    check(low_during_config, 1'b0);
    mode <= 3'h7;
    restart;
    repeat (200) @(posedge clock);
    check(rise_cnt, 0);
    close_out;
  end
endmodule
